// ==== include/drive_word_pkg.sv ====
// fieldbus drive command/state word layout and configuration codes
// assumes a single 100 MHz control clock domain
package drive_word_pkg;
  // command word bit positions
  localparam int CMD_OFF1 = 0;
  localparam int CMD_OFF2 = 1;
  localparam int CMD_OFF3 = 2;
  localparam int CMD_COAST = 3;
  localparam int CMD_QSTOP = 4;
  localparam int CMD_HOLD = 5;
  localparam int CMD_START = 6;
  localparam int CMD_RESET = 7;
  localparam int CMD_JOG1 = 8;
  localparam int CMD_JOG2 = 9;
  localparam int CMD_VALID = 10;
  localparam int CMD_SLOW = 11;
  localparam int CMD_CATCH = 12;
  localparam int CMD_SETUP_LSB = 13;
  localparam int CMD_SETUP_MSB = 14;
  localparam int CMD_REVERSE = 15;
  // state word bit positions
  localparam int ST_CTRL_READY = 0;
  localparam int ST_DRIVE_READY = 1;
  localparam int ST_ENABLE = 2;
  localparam int ST_TRIP = 3;
  localparam int ST_ON2 = 4;
  localparam int ST_ON3 = 5;
  localparam int ST_NO_START = 6;
  localparam int ST_WARNING = 7;
  localparam int ST_AT_REF = 8;
  localparam int ST_BUS_CTRL = 9;
  localparam int ST_FREQ_OK = 10;
  localparam int ST_RUNNING = 11;
  localparam int ST_AUTO_STOP = 12;
  localparam int ST_VOLT_EXC = 13;
  localparam int ST_TORQUE_EXC = 14;
  localparam int ST_TIMER_EXC = 15;
  // reset values
  localparam logic [15:0] CMD_RESET_VALUE = 16'h0000;
  localparam logic [1:0] SETUP_RESET_VALUE = 2'h0;
  // merge selector codes for bus bit vs digital input
  localparam logic [1:0] SEL_DIGITAL = 2'h0;
  localparam logic [1:0] SEL_BUS = 2'h1;
  localparam logic [1:0] SEL_OR = 2'h2;
  localparam logic [1:0] SEL_AND = 2'h3;
  // speed trim actions
  typedef enum logic [1:0] {
    TRIM_NONE = 2'b00,
    TRIM_DOWN = 2'b01,
    TRIM_UP = 2'b10
  } trim_t;
endpackage

// ==== src/bit_merge.sv ====
// merges one bus command bit with its digital input per a selector
// assumes both inputs are synchronous to the core clock
`timescale 1ns/100ps
module bit_merge (
  input wire logic [1:0] i_sel,
  input wire logic i_bus_bit,
  input wire logic i_din_bit,
  output logic o_merged
);
  always_comb begin
    unique case (i_sel)
      drive_word_pkg::SEL_DIGITAL: o_merged = i_din_bit;
      drive_word_pkg::SEL_BUS: o_merged = i_bus_bit;
      drive_word_pkg::SEL_OR: o_merged = i_bus_bit | i_din_bit;
      drive_word_pkg::SEL_AND: o_merged = i_bus_bit & i_din_bit;
    endcase
  end
endmodule

// ==== src/drive_word_ctrl.sv ====
// fieldbus command word decoder and state word builder for a motor drive
// assumes the telegram layer presents each command word with a one-cycle strobe,
// and the motor core supplies status levels on the same clock
//
// Contract
// - ignore the command word unless its data-valid bit 10 is set
// - bit 02 low forces a quick stop; relay at zero frequency
// - bit 03 low coasts; high permits start, merged with digital input
// - bit 04 low quick stops; high permits start, merged with input
// - bit 05 low freezes output frequency; high follows reference
// - bit 06 low ramp stops, relay at zero; high permits start
// - rising edge of bit 07 resets after switch-off and acknowledges fault
// - bits 08/09 select jog speeds, only if bit 04 low, 00-03 high
// - bit 11 high lowers speed reference by trim amount
// - bit 12 high raises reference; slow-down wins when both set
// - bits 13 and 14 pick one of four set-ups
// - set-up acts only in multi-set-up; running change needs linked set-ups
// - bit 15 reverses only when selector is bus, OR or AND
// - state bit 00 low if command 00/01/02 low or tripped
// - state bit 02 high only with command 00-02 high and no trip
// - state bit 03 high while tripped; restart needs reset
// - state bits 04 and 05 mirror command bits 01 and 02
// - state bit 06 sets after ack, OFF2/OFF3, power-up; clears on pattern
// - bit 07 shows warnings; bit 11 shows start or nonzero frequency
// - bit 08 speed at reference; bit 10 frequency within warning limits
// - bit 09 high when bus control accepted, low for local operation
// - bits 12-15 flag auto-stop, DC voltage, torque, thermal timer
// - command bit 00 low makes a normal ramp stop, relay at zero
// - command bit 01 low makes a coasting stop, relay at zero
`timescale 1ns/100ps
module drive_word_ctrl (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_cmd_strobe,
  input wire logic [15:0] i_drive_command_word,
  input wire logic [1:0] i_coast_sel,
  input wire logic [1:0] i_qstop_sel,
  input wire logic [1:0] i_start_sel,
  input wire logic [1:0] i_reverse_sel,
  input wire logic i_din_coast,
  input wire logic i_din_qstop,
  input wire logic i_din_start,
  input wire logic i_din_reverse,
  input wire logic i_multi_setup_mode,
  input wire logic i_setups_linked,
  input wire logic i_relay_at_zero_cfg,
  input wire logic i_drive_profile_mode,
  input wire logic i_tripped,
  input wire logic i_warning,
  input wire logic i_power_ok,
  input wire logic i_at_reference,
  input wire logic i_freq_in_limits,
  input wire logic i_freq_nonzero,
  input wire logic i_local_stop,
  input wire logic i_local_site,
  input wire logic i_overload_auto_stop,
  input wire logic i_dc_volt_fault,
  input wire logic i_torque_exceeded,
  input wire logic i_thermal_exceeded,
  output logic o_ramp_stop,
  output logic o_coast_stop,
  output logic o_quick_stop,
  output logic o_hold_freq,
  output logic o_run_permit,
  output logic o_fault_reset,
  output logic o_jog1,
  output logic o_jog2,
  output logic [1:0] o_speed_trim,
  output logic [1:0] o_setup_sel,
  output logic o_reverse,
  output logic o_stop_relay,
  output logic [15:0] o_drive_state_word
);
  logic [15:0] cmd;
  logic [15:0] next_cmd;
  logic reset_prev;
  logic next_reset_prev;
  logic no_start;
  logic next_no_start;
  logic [1:0] setup;
  logic [1:0] next_setup;
  logic coast_ok, qstop_ok, start_ok, rev_ok;
  logic accept;
  logic reset_rise;
  logic any_stop;
  logic [1:0] trim;
  logic ramp_stop, coast_stop, quick_stop, run_permit, jog_ok;
  logic [15:0] state_word;

  // power-up leaves all off bits low, so the drive starts stopped
  assign accept = i_cmd_strobe & i_drive_command_word[drive_word_pkg::CMD_VALID];

  always_comb begin
    next_cmd = cmd;
    if (accept) begin
      next_cmd = i_drive_command_word;
    end
  end

  bit_merge u_coast (.i_sel(i_coast_sel), .i_bus_bit(cmd[drive_word_pkg::CMD_COAST]),
    .i_din_bit(i_din_coast), .o_merged(coast_ok));
  bit_merge u_qstop (.i_sel(i_qstop_sel), .i_bus_bit(cmd[drive_word_pkg::CMD_QSTOP]),
    .i_din_bit(i_din_qstop), .o_merged(qstop_ok));
  bit_merge u_start (.i_sel(i_start_sel), .i_bus_bit(cmd[drive_word_pkg::CMD_START]),
    .i_din_bit(i_din_start), .o_merged(start_ok));
  bit_merge u_rev (.i_sel(i_reverse_sel), .i_bus_bit(cmd[drive_word_pkg::CMD_REVERSE]),
    .i_din_bit(i_din_reverse), .o_merged(rev_ok));

  always_comb begin
    coast_stop = ~cmd[drive_word_pkg::CMD_OFF2] | ~coast_ok;
    quick_stop = ~cmd[drive_word_pkg::CMD_OFF3];
    ramp_stop = ~cmd[drive_word_pkg::CMD_OFF1] | ~start_ok;
    // jog needs bit 04 low, which is itself a quick-stop request, so jog overrides it
    jog_ok = ~cmd[drive_word_pkg::CMD_QSTOP] & (&cmd[3:0]);
    if (~jog_ok && ~qstop_ok) begin
      quick_stop = 1'b1;
    end
    run_permit = ~coast_stop & ~quick_stop & ~ramp_stop & ~i_tripped;
    any_stop = coast_stop | quick_stop | ramp_stop;
  end

  always_comb begin
    if (cmd[drive_word_pkg::CMD_SLOW]) begin
      trim = drive_word_pkg::TRIM_DOWN;
    end else if (cmd[drive_word_pkg::CMD_CATCH]) begin
      trim = drive_word_pkg::TRIM_UP;
    end else begin
      trim = drive_word_pkg::TRIM_NONE;
    end
  end

  assign reset_rise = cmd[drive_word_pkg::CMD_RESET] & ~reset_prev;
  assign next_reset_prev = cmd[drive_word_pkg::CMD_RESET];

  always_comb begin
    next_setup = setup;
    if (i_multi_setup_mode && (!i_freq_nonzero || i_setups_linked)) begin
      // bit 13 is the low bit, so the pair maps straight to set-up minus one
      next_setup = {cmd[drive_word_pkg::CMD_SETUP_MSB], cmd[drive_word_pkg::CMD_SETUP_LSB]};
    end
  end

  always_comb begin
    next_no_start = no_start;
    if (reset_rise || ~cmd[drive_word_pkg::CMD_OFF2] || ~cmd[drive_word_pkg::CMD_OFF3]) begin
      next_no_start = 1'b1;
    end else if (~cmd[drive_word_pkg::CMD_OFF1] && cmd[drive_word_pkg::CMD_OFF2]
                 && cmd[drive_word_pkg::CMD_OFF3] && cmd[drive_word_pkg::CMD_VALID]) begin
      next_no_start = 1'b0;
    end
  end

  always_comb begin
    logic offs_high;
    offs_high = &cmd[2:0];
    state_word = 16'h0000;
    state_word[drive_word_pkg::ST_CTRL_READY] = offs_high & ~i_tripped;
    state_word[drive_word_pkg::ST_DRIVE_READY] = offs_high & ~i_tripped & i_power_ok;
    state_word[drive_word_pkg::ST_ENABLE] = offs_high & ~i_tripped & ~coast_stop;
    state_word[drive_word_pkg::ST_TRIP] = i_tripped;
    state_word[drive_word_pkg::ST_ON2] = cmd[drive_word_pkg::CMD_OFF2];
    state_word[drive_word_pkg::ST_ON3] = cmd[drive_word_pkg::CMD_OFF3];
    state_word[drive_word_pkg::ST_NO_START] = i_drive_profile_mode & no_start;
    state_word[drive_word_pkg::ST_WARNING] = i_warning;
    state_word[drive_word_pkg::ST_AT_REF] = i_at_reference;
    state_word[drive_word_pkg::ST_BUS_CTRL] = ~i_local_stop & ~i_local_site;
    state_word[drive_word_pkg::ST_FREQ_OK] = i_freq_in_limits;
    state_word[drive_word_pkg::ST_RUNNING] = run_permit | i_freq_nonzero;
    state_word[drive_word_pkg::ST_AUTO_STOP] = i_overload_auto_stop;
    state_word[drive_word_pkg::ST_VOLT_EXC] = i_dc_volt_fault;
    state_word[drive_word_pkg::ST_TORQUE_EXC] = i_torque_exceeded;
    state_word[drive_word_pkg::ST_TIMER_EXC] = i_thermal_exceeded;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cmd <= drive_word_pkg::CMD_RESET_VALUE;
      reset_prev <= 1'b0;
      no_start <= 1'b1;
      setup <= drive_word_pkg::SETUP_RESET_VALUE;
      o_ramp_stop <= 1'b1;
      o_coast_stop <= 1'b1;
      o_quick_stop <= 1'b1;
      o_hold_freq <= 1'b1;
      o_run_permit <= 1'b0;
      o_fault_reset <= 1'b0;
      o_jog1 <= 1'b0;
      o_jog2 <= 1'b0;
      o_speed_trim <= drive_word_pkg::TRIM_NONE;
      o_setup_sel <= drive_word_pkg::SETUP_RESET_VALUE;
      o_reverse <= 1'b0;
      o_stop_relay <= 1'b0;
      o_drive_state_word <= 16'h0000;
    end else begin
      cmd <= next_cmd;
      reset_prev <= next_reset_prev;
      no_start <= next_no_start;
      setup <= next_setup;
      o_ramp_stop <= ramp_stop;
      o_coast_stop <= coast_stop;
      o_quick_stop <= quick_stop & ~jog_ok;
      o_hold_freq <= ~cmd[drive_word_pkg::CMD_HOLD];
      o_run_permit <= run_permit;
      o_fault_reset <= reset_rise;
      o_jog1 <= jog_ok & cmd[drive_word_pkg::CMD_JOG1];
      o_jog2 <= jog_ok & cmd[drive_word_pkg::CMD_JOG2];
      o_speed_trim <= trim;
      o_setup_sel <= next_setup;
      o_reverse <= rev_ok & (i_reverse_sel != drive_word_pkg::SEL_DIGITAL || i_din_reverse);
      // relay only once the output has actually come to rest
      o_stop_relay <= i_relay_at_zero_cfg & any_stop & ~i_freq_nonzero;
      o_drive_state_word <= state_word;
    end
  end

  a_invalid_ignored: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (i_cmd_strobe && !i_drive_command_word[drive_word_pkg::CMD_VALID]) |=> $stable(cmd))
    else $error("invalid command word was taken");
  a_valid_taken: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    accept |=> (cmd == $past(i_drive_command_word)))
    else $error("valid command word not taken");
  a_reset_pulse: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    o_fault_reset |=> !o_fault_reset)
    else $error("fault reset longer than one cycle");
  a_reset_edge: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    ($rose(cmd[drive_word_pkg::CMD_RESET])) |=> o_fault_reset)
    else $error("reset edge missed");
  a_slow_wins: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (cmd[drive_word_pkg::CMD_SLOW] && cmd[drive_word_pkg::CMD_CATCH]) |=> o_speed_trim == drive_word_pkg::TRIM_DOWN)
    else $error("slow-down did not win");
  a_jog_gate: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    o_jog1 |-> $past(cmd[drive_word_pkg::CMD_QSTOP] == 1'b0 && cmd[3:0] == 4'hF))
    else $error("jog outside permit");
  a_ctrl_ready: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (i_tripped || !cmd[0] || !cmd[1] || !cmd[2]) |=> !o_drive_state_word[drive_word_pkg::ST_CTRL_READY])
    else $error("control ready while off or tripped");
  a_mirror_bits: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    ##1 o_drive_state_word[5:4] == $past(cmd[2:1]))
    else $error("state bits 4/5 do not mirror command");
  a_no_start_clear: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (cmd[2:0] == 3'h6 && cmd[drive_word_pkg::CMD_VALID] && !reset_rise) |=> !no_start)
    else $error("start-not-possible not cleared");
  a_no_start_set: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (!cmd[drive_word_pkg::CMD_OFF2] || !cmd[drive_word_pkg::CMD_OFF3]) |=> no_start)
    else $error("start-not-possible not set after off command");
  a_ramp_off1: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    !cmd[drive_word_pkg::CMD_OFF1] |=> o_ramp_stop)
    else $error("off1 without ramp stop");
  a_coast_off2: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    !cmd[drive_word_pkg::CMD_OFF2] |=> o_coast_stop)
    else $error("off2 without coasting stop");
  a_quick_off3: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    !cmd[drive_word_pkg::CMD_OFF3] |=> o_quick_stop)
    else $error("off3 without quick stop");
  a_relay_rest: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    o_stop_relay |-> $past(!i_freq_nonzero && i_relay_at_zero_cfg))
    else $error("stop relay while turning or not configured");
  a_coast_merge: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (i_coast_sel == drive_word_pkg::SEL_BUS && !cmd[drive_word_pkg::CMD_COAST]) |=> o_coast_stop)
    else $error("bus coast bit ignored");
  a_qstop_merge: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (i_qstop_sel == drive_word_pkg::SEL_BUS && !cmd[drive_word_pkg::CMD_QSTOP] && !(&cmd[3:0])) |=> o_quick_stop)
    else $error("bus quick-stop bit ignored");
  a_hold_freq: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    ##1 o_hold_freq == !$past(cmd[drive_word_pkg::CMD_HOLD]))
    else $error("hold output does not follow command");
  a_start_merge: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (i_start_sel == drive_word_pkg::SEL_BUS && !cmd[drive_word_pkg::CMD_START]) |=> (o_ramp_stop && !o_run_permit))
    else $error("bus start bit low without ramp stop");
  a_trim_none: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (!cmd[drive_word_pkg::CMD_SLOW] && !cmd[drive_word_pkg::CMD_CATCH]) |=> o_speed_trim == drive_word_pkg::TRIM_NONE)
    else $error("speed trim without request");
  a_setup_pick: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (i_multi_setup_mode && !i_freq_nonzero) |=> o_setup_sel == $past({cmd[14], cmd[13]}))
    else $error("set-up not taken from command bits");
  a_setup_hold: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    !i_multi_setup_mode |=> $stable(o_setup_sel))
    else $error("set-up changed outside multi set-up mode");
  a_reverse_bus: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (i_reverse_sel == drive_word_pkg::SEL_BUS) |=> o_reverse == $past(cmd[drive_word_pkg::CMD_REVERSE]))
    else $error("reverse does not follow bus bit");
  a_enable_bit: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    o_drive_state_word[drive_word_pkg::ST_ENABLE] |-> $past(&cmd[2:0] && !i_tripped))
    else $error("enable shown while off or tripped");
  a_trip_bit: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    ##1 o_drive_state_word[drive_word_pkg::ST_TRIP] == $past(i_tripped))
    else $error("trip bit does not follow trip");
  a_trip_run: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    i_tripped |=> !o_run_permit)
    else $error("run permitted while tripped");
  a_running_bit: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    i_freq_nonzero |=> o_drive_state_word[drive_word_pkg::ST_RUNNING])
    else $error("turning motor not shown as running");
  a_at_ref_bit: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    ##1 o_drive_state_word[drive_word_pkg::ST_AT_REF] == $past(i_at_reference))
    else $error("at-reference bit does not follow core");
  a_bus_ctrl: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (i_local_stop || i_local_site) |=> !o_drive_state_word[drive_word_pkg::ST_BUS_CTRL])
    else $error("bus control shown during local operation");
  a_flag_bits: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    ##1 o_drive_state_word[15:12] == $past({i_thermal_exceeded, i_torque_exceeded,
    i_dc_volt_fault, i_overload_auto_stop}))
    else $error("limit flags do not follow core");
endmodule

// ==== bench/fieldbus_master_model.sv ====
// fieldbus master model: sends command words, reads the state word back
// assumes the drive samples the word with the strobe on the rising clock edge
`timescale 1ns/100ps
module fieldbus_master_model (
  input wire logic i_core_clk,
  input wire logic [15:0] i_drive_state_word,
  output logic o_cmd_strobe,
  output logic [15:0] o_drive_command_word
);
  logic [15:0] last_state;
  initial begin
    o_cmd_strobe = 1'b0;
    o_drive_command_word = 16'h0000;
    last_state = 16'h0000;
  end
  // one telegram, then read back after the answer has settled
  task automatic send(input logic [15:0] w);
    @(posedge i_core_clk);
    o_cmd_strobe <= 1'b1;
    o_drive_command_word <= w;
    @(posedge i_core_clk);
    o_cmd_strobe <= 1'b0;
    // word no longer qualified: show the inverse, never a stale copy
    o_drive_command_word <= ~w;
    repeat (3) @(posedge i_core_clk);
    #1 last_state = i_drive_state_word;
  endtask
endmodule

// ==== bench/drive_word_ctrl_tb.sv ====
// self-checking bench for the command word decoder and state word builder
// assumes the master model in the same folder
`timescale 1ns/100ps
module drive_word_ctrl_tb;
  localparam logic [15:0] W0 = 16'h047F;
  localparam int SB [6] = '{0, 1, 2, 3, 5, 6};
  // {ramp, coast, quick, hold, relay, sw6, sw5, sw4, sw0}
  localparam logic [8:0] SX [6] = '{9'h116, 9'h09C, 9'h05A, 9'h09F, 9'h02F, 9'h11F};
  localparam logic [11:0] ST [12] = '{12'h006, 12'h00C, 12'h014, 12'h084, 12'h044,
    12'h104, 12'h204, 12'h404, 12'h804, 12'h005, 12'h000, 12'h025};
  localparam logic [15:0] SE [12] = '{16'h0A87, 16'h0B07, 16'h0E07, 16'h0807, 16'h0807,
    16'h1A07, 16'h2A07, 16'h4A07, 16'h8A07, 16'h0208, 16'h0A05, 16'h0A08};
  logic i_core_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic [11:0] st = 12'h004;
  logic [3:0] cfg = 4'hD;
  logic [7:0] sel = 8'h55;
  logic [3:0] din = 4'hF;
  logic strobe, ramp, coast, quick, hold, permit, freset, jog1, jog2, rev, relay;
  logic [15:0] word, sw;
  logic [1:0] trim, setup;
  int n_mismatch = 0;
  int checked = 0;
  int n_pulse = 0;
  always #5 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) if (freset === 1'b1) n_pulse++;
  fieldbus_master_model i_master (.i_core_clk(i_core_clk), .i_drive_state_word(sw),
    .o_cmd_strobe(strobe), .o_drive_command_word(word));
  drive_word_ctrl i_dut (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_cmd_strobe(strobe),
    .i_drive_command_word(word), .i_coast_sel(sel[1:0]), .i_qstop_sel(sel[3:2]),
    .i_start_sel(sel[5:4]), .i_reverse_sel(sel[7:6]), .i_din_coast(din[0]), .i_din_qstop(din[1]),
    .i_din_start(din[2]), .i_din_reverse(din[3]), .i_multi_setup_mode(cfg[0]),
    .i_setups_linked(cfg[1]), .i_relay_at_zero_cfg(cfg[2]), .i_drive_profile_mode(cfg[3]),
    .i_tripped(st[0]), .i_warning(st[1]), .i_power_ok(st[2]), .i_at_reference(st[3]),
    .i_freq_in_limits(st[4]), .i_freq_nonzero(st[5]), .i_local_stop(st[6]), .i_local_site(st[7]),
    .i_overload_auto_stop(st[8]), .i_dc_volt_fault(st[9]), .i_torque_exceeded(st[10]),
    .i_thermal_exceeded(st[11]), .o_ramp_stop(ramp), .o_coast_stop(coast), .o_quick_stop(quick),
    .o_hold_freq(hold), .o_run_permit(permit), .o_fault_reset(freset), .o_jog1(jog1), .o_jog2(jog2),
    .o_speed_trim(trim), .o_setup_sel(setup), .o_reverse(rev), .o_stop_relay(relay),
    .o_drive_state_word(sw));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic set_st(input logic [11:0] v);
    @(posedge i_core_clk);
    st <= v;
    repeat (2) @(posedge i_core_clk);
    #1;
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #100us;
    n_mismatch++;
    print_verdict();
  end
  initial begin
    repeat (5) @(posedge i_core_clk);
    #1 check({ramp, coast, quick, hold}, 16'h000F);
    check(sw, 16'h0000);
    @(posedge i_core_clk) i_rst_b <= 1'b1;
    i_master.send(W0);
    check(i_master.last_state & 16'hFFFD, 16'h0A75);
    check({ramp, coast, quick, hold, permit}, 16'h0001);
    // words without the valid bit leave everything as it was
    i_master.send(16'h0000);
    check({ramp, permit, sw[0]}, 16'h0003);
    for (int i = 0; i < 6; i++) begin
      i_master.send(W0 & ~(16'h0001 << SB[i]));
      check({ramp, coast, quick, hold, relay, sw[6], sw[5], sw[4], sw[0]}, SX[i]);
    end
    i_master.send(16'h056F);
    check({jog1, jog2}, 16'h0002);
    i_master.send(16'h066F);
    check({jog1, jog2}, 16'h0001);
    i_master.send(16'h056E);
    check({jog1, jog2}, 16'h0000);
    check(quick, 16'h0001);
    i_master.send(W0);
    check(quick, 16'h0000);
    i_master.send(W0 | 16'h0080);
    i_master.send(W0 | 16'h0080);
    check(16'(n_pulse), 16'h0001);
    for (int k = 0; k < 4; k++) begin
      i_master.send(W0 | (16'(k) << 11));
      check(trim, k == 2 ? drive_word_pkg::TRIM_UP : (k != 0 ? drive_word_pkg::TRIM_DOWN : 2'h0));
    end
    @(posedge i_core_clk) cfg <= 4'hF;
    for (int k = 0; k < 4; k++) begin
      i_master.send(W0 | (16'(k) << 13));
      check(setup, 16'(k));
    end
    // turning motor without linked set-ups keeps the old set-up
    @(posedge i_core_clk);
    cfg <= 4'hD;
    st <= 12'h024;
    i_master.send(W0);
    check(setup, 16'h0003);
    @(posedge i_core_clk);
    cfg <= 4'hC;
    st <= 12'h004;
    i_master.send(16'h2400);
    check(setup, 16'h0003);
    @(posedge i_core_clk) cfg <= 4'hD;
    i_master.send(16'h2400);
    check(setup, 16'h0001);
    // merge selectors, digital inputs and config levels away from their defaults
    @(posedge i_core_clk);
    sel <= 8'h32;
    din <= 4'hB;
    cfg <= 4'h1;
    i_master.send(W0 & 16'hFFF7);
    check({ramp, coast, quick, rev, relay, sw[6]}, 16'h0024);
    @(posedge i_core_clk);
    din <= 4'h4;
    i_master.send(16'h8477);
    check({ramp, coast, quick, rev, relay, sw[6]}, 16'h0018);
    @(posedge i_core_clk);
    sel <= 8'h55;
    din <= 4'hF;
    cfg <= 4'hD;
    i_master.send(W0 | 16'h8000);
    check(rev, 16'h0001);
    i_master.send(W0);
    check(rev, 16'h0000);
    for (int i = 0; i < 12; i++) begin
      set_st(ST[i]);
      check(sw & 16'hFF8F, SE[i]);
    end
    set_st(12'h004);
    print_verdict();
  end
endmodule
